/* bench/nopb_assertions.sv */
`timescale 1ns/1ns

// ********
// Request and byte stream checks
// ********
module nopb_assertions (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic [7:0] req_type_i,
  input wire logic req_ready_o,
  input wire logic req_error_o,
  input wire logic out_ready_i,
  input wire logic out_valid_o,
  input wire logic [7:0] out_data_o,
  input wire logic out_last_o,
  input wire logic [7:0] out_type_o,
  input wire logic [15:0] out_len_o,
  input wire logic done_o
);
  logic take;
  logic hs;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Request taken and byte handshake
  assign take = req_i && req_ready_o;
  assign hs = out_valid_o && out_ready_i;

  a_len_qstd:
    assert property (take && req_type_i == 8'h1b |=> out_type_o == 8'h1b
      && out_len_o == 16'h0010) else $error("type 27 length wrong");
  a_len_sensors:
    assert property (take && req_type_i == 8'h1c |=> out_type_o == 8'h1c
      && out_len_o == 16'h0030) else $error("type 28 length wrong");
  a_len_gnss:
    assert property (take && req_type_i == 8'h1d |=> out_type_o == 8'h1d
      && out_len_o == 16'h004a) else $error("type 29 length wrong");
  a_len_counts:
    assert property (take && req_type_i == 8'h1e |=> out_type_o == 8'h1e
      && out_len_o == 16'h000d) else $error("type 30 length wrong");
  a_busy_rise:
    assert property (take && req_type_i inside {[8'h1b:8'h1e]}
      |=> !req_ready_o) else $error("ready stayed high after accept");
  a_bad_type:
    assert property (take && !(req_type_i inside {[8'h1b:8'h1f]})
      |=> req_error_o && req_ready_o ##1 !req_error_o)
      else $error("unsupported type not flagged");
  a_hold_stall:
    assert property (out_valid_o && !out_ready_i |=> out_valid_o
      && $stable(out_data_o) && $stable(out_last_o))
      else $error("byte changed while stalled");
  a_no_bubble:
    assert property (hs && !out_last_o |=> out_valid_o)
      else $error("gap inside payload");
  a_last_done:
    assert property (hs && out_last_o |=> done_o && req_ready_o
      && !out_valid_o ##1 !done_o) else $error("completion wrong");
  a_idle_quiet:
    assert property (req_ready_o |-> !out_valid_o)
      else $error("byte offered while idle");

  // Main scenarios
  c_stall: cover property (out_valid_o && !out_ready_i);
  c_error: cover property (req_error_o);
  c_list: cover property (done_o && out_type_o == 8'h1f);
endmodule : nopb_assertions

/* bench/nopb_host_model.sv */
`timescale 1ns/1ns

// ********
// Framer sink
// ********
module nopb_host_model (
  input wire logic sys_clk_i,
  input wire logic clr_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic last_i,
  output logic ready_o
);
  logic [7:0] got [0:255];
  int n = 0;
  int last_at = -1;
  logic ph = 1'b0;

  // Stalling drops ready every other cycle
  assign ready_o = !stall_i || ph;

  // Take one byte per handshake, counting again from each clear
  always @(posedge sys_clk_i)
  begin
    ph <= !ph;
    if (clr_i)
    begin
      n <= 0;
      last_at <= -1;
    end
    else if (valid_i && ready_o)
    begin
      got[n] <= data_i;
      n <= n + 1;
      if (last_i)
        last_at <= n;
    end
  end
endmodule : nopb_host_model

/* bench/tb_top.sv */
`timescale 1ns/1ns

bind nopb_packet_builder nopb_assertions CHK (.sys_clk_i, .nrst_i, .req_i,
  .req_type_i, .req_ready_o, .req_error_o, .out_ready_i, .out_valid_o,
  .out_data_o, .out_last_o, .out_type_o, .out_len_o, .done_o);

// ********
// Bench
// ********
module tb_top;
  logic sys_clk_i, nrst_i, req_i, req_ready_o, req_error_o, clr, stall;
  logic [7:0] req_type_i, out_type_o, out_data_o;
  logic [31:0] q_s_sd_i, q_x_sd_i, q_y_sd_i, q_z_sd_i, imu_temp_i;
  logic [31:0] acc_x_i, acc_y_i, acc_z_i, gyr_x_i, gyr_y_i, gyr_z_i;
  logic [31:0] mag_x_i, mag_y_i, mag_z_i, gnss_secs_i, gnss_usec_i;
  logic [63:0] gnss_lat_i, gnss_lon_i, gnss_hgt_i;
  logic [31:0] gnss_vn_i, gnss_ve_i, gnss_vd_i, gnss_lat_sd_i;
  logic [31:0] gnss_lon_sd_i, gnss_hgt_sd_i, gnss_tilt_i, gnss_hdg_i;
  logic [31:0] gnss_tilt_sd_i, gnss_hdg_sd_i;
  logic [31:0] horizontal_precision_dilution_i;
  logic [31:0] vertical_precision_dilution_i;
  logic [15:0] gnss_rx_i, sat_azim_i, out_len_o;
  logic [2:0] fix_class_i;
  logic doppler_valid_i, time_valid_i, ext_gnss_i, tilt_valid_i;
  logic heading_valid_i, float_amb_i, sat_wr_i, out_ready_i;
  logic out_valid_o, out_last_o, done_o;
  logic [6:0] sats_rx_i;
  logic [7:0] cnt_gps_i, cnt_glonass_i, cnt_beidou_i, cnt_galileo_i;
  logic [7:0] cnt_sbas_i, satellite_number_i, sat_freq_i, sat_elev_i;
  logic [7:0] sat_snr_i;
  logic [5:0] sat_count_i, sat_rx_i;
  logic [4:0] sat_wr_idx_i;
  logic [3:0] sat_system_i;
  logic [1127:0] pool;
  logic [7:0] exp_q [$];
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;

  nopb_packet_builder DUT (.*);

  nopb_host_model HOST (.sys_clk_i, .clr_i(clr), .stall_i(stall),
    .valid_i(out_valid_o), .data_i(out_data_o), .last_i(out_last_o),
    .ready_o(out_ready_i));

  // Clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Hang guard
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      end_of_test();
    end
  end

  task chk(string what, logic [63:0] seen, logic [63:0] expv);
    total_checks++;
    if (seen !== expv)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, expv, seen);
    end
  endtask : chk

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // Expected bytes, low first; fields with a clear keep bit are zero
  function automatic void walk(logic [639:0] v, logic [15:0] keep, int nf,
    logic [63:0] sz);
    int o;
    o = 0;
    for (int f = 0; f < nf; f++)
    begin
      for (int b = 0; b < sz[f*4 +: 4]; b++)
        exp_q.push_back(keep[f] ? v[(o + b)*8 +: 8] : 8'h00);
      o += sz[f*4 +: 4];
    end
  endfunction : walk

  task request(logic [7:0] t);
    @(posedge sys_clk_i);
    clr <= 1'b1;
    req_i <= 1'b1;
    req_type_i <= t;
    @(posedge sys_clk_i);
    clr <= 1'b0;
    req_i <= 1'b0;
    #1;
  endtask : request

  task send(logic [7:0] t, logic [15:0] len);
    int k;
    k = 0;
    request(t);
    chk("busy", req_ready_o, len == 16'h0000);
    while (done_o !== 1'b1 && k < 2000)
    begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    chk("done", done_o, 1'b1);
    chk("type", out_type_o, t);
    chk("length", out_len_o, len);
    chk("byte count", HOST.n, len);
    chk("last byte", HOST.last_at + 1, len);
    for (int i = 0; i < len; i++)
      chk("payload byte", HOST.got[i], exp_q[i]);
    exp_q.delete();
  endtask : send

  task t_qstd;
    walk({q_z_sd_i, q_y_sd_i, q_x_sd_i, q_s_sd_i}, 16'h000f, 4, 64'h4444);
    send(8'h1b, 16'h0010);
    $display("test orientation deviation done");
  endtask : t_qstd

  task t_raw_sensors;
    @(posedge sys_clk_i);
    stall <= 1'b1;
    walk({imu_temp_i, mag_z_i, mag_y_i, mag_x_i, gyr_z_i, gyr_y_i, gyr_x_i,
      acc_z_i, acc_y_i, acc_x_i}, 16'h03ff, 12, 64'h4444_4444_4444);
    send(8'h1c, 16'h0030);
    $display("test raw sensors done");
  endtask : t_raw_sensors

  task t_raw_gnss;
    logic [15:0] st;
    for (int k = 0; k < 9; k++)
    begin
      @(posedge sys_clk_i);
      stall <= k[0];
      fix_class_i <= 3'(k);
      {float_amb_i, heading_valid_i, tilt_valid_i, ext_gnss_i,
        time_valid_i, doppler_valid_i} <= 6'(k * 11);
      gnss_rx_i <= k == 8 ? 16'h7ff0 : (k[0] ? 16'hffff : 16'hc3a5);
      #1;
      st = {7'h00, float_amb_i, heading_valid_i, tilt_valid_i, ext_gnss_i,
        time_valid_i, doppler_valid_i, fix_class_i};
      walk({st, gnss_hdg_sd_i, gnss_tilt_sd_i, gnss_hdg_i, gnss_tilt_i,
        gnss_hgt_sd_i, gnss_lon_sd_i, gnss_lat_sd_i, gnss_vd_i, gnss_ve_i,
        gnss_vn_i, gnss_hgt_i, gnss_lon_i, gnss_lat_i, gnss_usec_i,
        gnss_secs_i}, gnss_rx_i, 16, 64'h2444_4444_4448_8844);
      st = gnss_rx_i[15] ? st : 16'h0000;
      send(8'h1d, 16'h004a);
      chk("status", {HOST.got[73], HOST.got[72]}, st);
      chk("fix", HOST.got[72][2:0], st[2:0]);
    end
    $display("test raw receiver done");
  endtask : t_raw_gnss

  task t_sat_counts;
    @(posedge sys_clk_i);
    sats_rx_i <= 7'h55;
    #1;
    walk({cnt_sbas_i, cnt_galileo_i, cnt_beidou_i, cnt_glonass_i, cnt_gps_i,
      vertical_precision_dilution_i, horizontal_precision_dilution_i},
      {9'h000, sats_rx_i}, 7, 64'h0111_1144);
    send(8'h1e, 16'h000d);
    $display("test satellite counts done");
  endtask : t_sat_counts

  task t_sat_list;
    logic [55:0] e;
    logic [5:0] rx;
    for (int k = 0; k < 10; k++)
    begin
      rx = k == 5 ? 6'h2d : 6'h3f;
      e = {8'(40 + k), 16'(k * 300 + 7), 8'(k * 9), 8'(8'h01 << (k % 8)),
        8'(k * 3 + 1), 8'(k == 9 ? 0 : k)};
      @(posedge sys_clk_i);
      sat_wr_i <= 1'b1;
      sat_wr_idx_i <= 5'(k);
      sat_rx_i <= rx;
      sat_system_i <= k == 9 ? 4'hf : 4'(k);
      {sat_snr_i, sat_azim_i, sat_elev_i, sat_freq_i,
        satellite_number_i} <= e[55:8];
      walk(e, {10'h000, rx}, 6, 64'h0012_1111);
    end
    @(posedge sys_clk_i);
    sat_wr_i <= 1'b0;
    sat_count_i <= 6'h0a;
    send(8'h1f, 16'h0046);
    @(posedge sys_clk_i);
    sat_count_i <= 6'h00;
    send(8'h1f, 16'h0000);
    $display("test satellite list done");
  endtask : t_sat_list

  task t_refuse;
    for (int k = 0; k < 2; k++)
    begin
      request(k ? 8'h20 : 8'h1a);
      chk("error pulse", req_error_o, 1'b1);
      chk("still idle", {req_ready_o, out_valid_o}, 2'b10);
    end
    $display("test refused types done");
  endtask : t_refuse

  // Stimulus
  initial
  begin
    for (int i = 0; i < 141; i++)
      pool[i*8 +: 8] = 8'(i + 1);
    {q_s_sd_i, q_x_sd_i, q_y_sd_i, q_z_sd_i, acc_x_i, acc_y_i, acc_z_i,
      gyr_x_i, gyr_y_i, gyr_z_i, mag_x_i, mag_y_i, mag_z_i, imu_temp_i,
      gnss_secs_i, gnss_usec_i, gnss_lat_i, gnss_lon_i, gnss_hgt_i,
      gnss_vn_i, gnss_ve_i, gnss_vd_i, gnss_lat_sd_i, gnss_lon_sd_i,
      gnss_hgt_sd_i, gnss_tilt_i, gnss_hdg_i, gnss_tilt_sd_i, gnss_hdg_sd_i,
      horizontal_precision_dilution_i, vertical_precision_dilution_i,
      cnt_gps_i, cnt_glonass_i, cnt_beidou_i, cnt_galileo_i,
      cnt_sbas_i} = pool;
    {nrst_i, req_i, req_type_i, stall, clr, sat_wr_i} = 13'h002;
    {gnss_rx_i, sats_rx_i, fix_class_i} = 26'h3ff_fff8;
    {doppler_valid_i, time_valid_i, ext_gnss_i, tilt_valid_i} = 4'h0;
    {heading_valid_i, float_amb_i, sat_count_i, sat_wr_idx_i} = 13'h0000;
    {sat_rx_i, sat_system_i, satellite_number_i, sat_freq_i} = 26'h0;
    {sat_elev_i, sat_azim_i, sat_snr_i} = 32'h0;
    repeat (6) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    #1;
    chk("idle after reset", {req_ready_o, out_valid_o}, 2'b10);
    t_qstd();
    t_raw_sensors();
    t_raw_gnss();
    t_sat_counts();
    t_sat_list();
    t_refuse();
    end_of_test();
  end
endmodule : tb_top

/* include/nopb_params.svh */
`ifndef NOPB_PARAMS_SVH
`define NOPB_PARAMS_SVH

// Packet identifiers
`define NOPB_ID_QSTD 8'h1b
`define NOPB_ID_RAWSNS 8'h1c
`define NOPB_ID_RAWGNSS 8'h1d
`define NOPB_ID_SATS 8'h1e
`define NOPB_ID_SATLIST 8'h1f

// Payload lengths in bytes
`define NOPB_LEN_QSTD 16'h0010
`define NOPB_LEN_RAWSNS 16'h0030
`define NOPB_LEN_RAWGNSS 16'h004a
`define NOPB_LEN_SATS 16'h000d
`define NOPB_SAT_ENTRY_LEN 8'h07
`define NOPB_MAX_LEN 74

// Raw sensors packet offsets
`define NOPB_R28_MAG 24
`define NOPB_R28_TEMP 36
`define NOPB_R28_RSV0 40
`define NOPB_R28_RSV1 44

// Raw receiver packet offsets
`define NOPB_R29_SECS 0
`define NOPB_R29_USEC 4
`define NOPB_R29_LAT 8
`define NOPB_R29_LON 16
`define NOPB_R29_HGT 24
`define NOPB_R29_VN 32
`define NOPB_R29_VE 36
`define NOPB_R29_VD 40
`define NOPB_R29_LATSD 44
`define NOPB_R29_LONSD 48
`define NOPB_R29_HGTSD 52
`define NOPB_R29_TILT 56
`define NOPB_R29_HDG 60
`define NOPB_R29_TILTSD 64
`define NOPB_R29_HDGSD 68
`define NOPB_R29_STATUS 72

// Receiver status word bit positions
`define NOPB_ST_DOPPLER 3
`define NOPB_ST_TIME 4
`define NOPB_ST_EXT 5
`define NOPB_ST_TILT 6
`define NOPB_ST_HDG 7
`define NOPB_ST_FLOAT 8

// Satellite counts packet offsets
`define NOPB_R30_HPD 0
`define NOPB_R30_VPD 4
`define NOPB_R30_CNT 8

// Satellite list storage
`define NOPB_SAT_DEPTH 32
`define NOPB_SYS_MAX 4'h8

`endif

/* include/nopb_pkg.sv */
package nopb_pkg;

  typedef enum logic {ST_IDLE, ST_SEND} nopb_state_type;

  // Satellite system codes
  typedef enum logic [3:0] {
    SYS_UNKNOWN, SYS_GPS, SYS_GLONASS, SYS_BEIDOU, SYS_GALILEO,
    SYS_SBAS, SYS_QZSS, SYS_CORR_A, SYS_CORR_B
  } nopb_sys_type;

  // Fix classes
  typedef enum logic [2:0] {
    FIX_NONE, FIX_2D, FIX_3D, FIX_SBAS, FIX_DIFF, FIX_CORR,
    FIX_RTK_FLOAT, FIX_RTK_FIXED
  } nopb_fix_type;

endpackage : nopb_pkg

/* verilog/nopb_packet_builder.sv */
`timescale 1ns/1ns
`include "nopb_params.svh"

// Summary of operation
// RULE1 - Type 27: four quaternion deviations, 16 bytes
// RULE2 - Type 28: accel, gyro, magnetometer floats, 48 bytes
// RULE3 - Type 28: temperature at 36, zeros at 40,44
// RULE4 - Type 29: 74 bytes, receiver data uncorrected
// RULE5 - Type 29: no antenna offset or lever arm
// RULE6 - Other packets carry the corrected solution
// RULE7 - Unreceived receiver fields are sent as zero
// RULE8 - Type 29: time, position, velocity at offsets
// RULE9 - Type 29: position deviations at 44, 48, 52
// RULE10 - Type 29: tilt, heading and deviations at 56-68
// RULE11 - Type 29: 16-bit status word at 72
// RULE12 - Status bits 0-2 hold the fix class
// RULE13 - Status flags bits 3-8, bits 9-15 zero
// RULE14 - Type 30: precision dilutions and five counts
// RULE15 - Type 31: seven bytes per tracked satellite
// RULE16 - Entry: system, number, frequencies, elevation, azimuth, ratio
// RULE17 - System codes 0 to 8
// RULE18 - Fix class codes 0 to 7
// RULE19 - Frequency bit set, bits 0 to 7
// RULE20 - Low byte first, no padding
// RULE21 - Next payload only after previous fully sent

module nopb_packet_builder (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic [7:0] req_type_i,
  output logic req_ready_o,
  output logic req_error_o,
  input wire logic [31:0] q_s_sd_i,
  input wire logic [31:0] q_x_sd_i,
  input wire logic [31:0] q_y_sd_i,
  input wire logic [31:0] q_z_sd_i,
  input wire logic [31:0] acc_x_i,
  input wire logic [31:0] acc_y_i,
  input wire logic [31:0] acc_z_i,
  input wire logic [31:0] gyr_x_i,
  input wire logic [31:0] gyr_y_i,
  input wire logic [31:0] gyr_z_i,
  input wire logic [31:0] mag_x_i,
  input wire logic [31:0] mag_y_i,
  input wire logic [31:0] mag_z_i,
  input wire logic [31:0] imu_temp_i,
  input wire logic [15:0] gnss_rx_i,
  input wire logic [31:0] gnss_secs_i,
  input wire logic [31:0] gnss_usec_i,
  input wire logic [63:0] gnss_lat_i,
  input wire logic [63:0] gnss_lon_i,
  input wire logic [63:0] gnss_hgt_i,
  input wire logic [31:0] gnss_vn_i,
  input wire logic [31:0] gnss_ve_i,
  input wire logic [31:0] gnss_vd_i,
  input wire logic [31:0] gnss_lat_sd_i,
  input wire logic [31:0] gnss_lon_sd_i,
  input wire logic [31:0] gnss_hgt_sd_i,
  input wire logic [31:0] gnss_tilt_i,
  input wire logic [31:0] gnss_hdg_i,
  input wire logic [31:0] gnss_tilt_sd_i,
  input wire logic [31:0] gnss_hdg_sd_i,
  input wire logic [2:0] fix_class_i,
  input wire logic doppler_valid_i,
  input wire logic time_valid_i,
  input wire logic ext_gnss_i,
  input wire logic tilt_valid_i,
  input wire logic heading_valid_i,
  input wire logic float_amb_i,
  input wire logic [6:0] sats_rx_i,
  input wire logic [31:0] horizontal_precision_dilution_i,
  input wire logic [31:0] vertical_precision_dilution_i,
  input wire logic [7:0] cnt_gps_i,
  input wire logic [7:0] cnt_glonass_i,
  input wire logic [7:0] cnt_beidou_i,
  input wire logic [7:0] cnt_galileo_i,
  input wire logic [7:0] cnt_sbas_i,
  input wire logic [5:0] sat_count_i,
  input wire logic sat_wr_i,
  input wire logic [4:0] sat_wr_idx_i,
  input wire logic [5:0] sat_rx_i,
  input wire logic [3:0] sat_system_i,
  input wire logic [7:0] satellite_number_i,
  input wire logic [7:0] sat_freq_i,
  input wire logic [7:0] sat_elev_i,
  input wire logic [15:0] sat_azim_i,
  input wire logic [7:0] sat_snr_i,
  input wire logic out_ready_i,
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  output logic out_last_o,
  output logic [7:0] out_type_o,
  output logic [15:0] out_len_o,
  output logic done_o
);

  localparam int PW = 8 * `NOPB_MAX_LEN;

  // ****************************************
  // Helper functions
  // ****************************************

  // Zero a field that the receiver never delivered
  function automatic logic [63:0] rx_gate(input logic [63:0] v,
                                          input logic ok);
    rx_gate = ok ? v : 64'h0; // see RULE7
  endfunction : rx_gate

  // Payload length for a packet type, zero if unsupported
  function automatic logic [15:0] pkt_len(input logic [7:0] t,
                                          input logic [5:0] n);
    unique case (t)
      `NOPB_ID_QSTD: pkt_len = `NOPB_LEN_QSTD;
      `NOPB_ID_RAWSNS: pkt_len = `NOPB_LEN_RAWSNS;
      `NOPB_ID_RAWGNSS: pkt_len = `NOPB_LEN_RAWGNSS;
      `NOPB_ID_SATS: pkt_len = `NOPB_LEN_SATS;
      `NOPB_ID_SATLIST: pkt_len = 16'({8'h0, `NOPB_SAT_ENTRY_LEN} *
                                       {10'h0, n}); // see RULE15
      default: pkt_len = 16'h0;
    endcase
  endfunction : pkt_len

  // ****************************************
  // Payload assembly
  // ****************************************

  nopb_pkg::nopb_state_type st_r;
  logic [PW-1:0] pay;
  logic [PW-1:0] pay_r;
  logic [15:0] status;
  logic [2:0] fix;
  logic supported;
  logic [7:0] type_r;
  logic [15:0] left_r;
  logic [6:0] idx_r;
  logic [4:0] ent_r;
  logic [2:0] sub_r;
  logic [7:0] tbl_byte;
  logic [55:0] entry;
  logic [3:0] sys_code;
  logic take;
  logic load;
  logic fin;

  // Receiver status word; raw class passes through only when gnss_rx_i[15] is set
  always_comb
  begin
    fix = gnss_rx_i[15] ? fix_class_i : nopb_pkg::FIX_NONE; // see RULE18
    status = 16'h0; // see RULE13
    status[2:0] = fix; // see RULE12
    status[`NOPB_ST_DOPPLER] = doppler_valid_i;
    status[`NOPB_ST_TIME] = time_valid_i;
    status[`NOPB_ST_EXT] = ext_gnss_i;
    status[`NOPB_ST_TILT] = tilt_valid_i;
    status[`NOPB_ST_HDG] = heading_valid_i;
    status[`NOPB_ST_FLOAT] = float_amb_i; // see RULE13
    if (!gnss_rx_i[15])
      status = 16'h0; // see RULE7
  end

  // Little-endian byte image, field by field with no gaps
  always_comb
  begin
    pay = '0; // see RULE20
    unique case (req_type_i)
      `NOPB_ID_QSTD:
        pay[127:0] = {q_z_sd_i, q_y_sd_i, q_x_sd_i, q_s_sd_i}; // see RULE1
      `NOPB_ID_RAWSNS:
      begin
        pay[8*`NOPB_R28_MAG-1:0] = {gyr_z_i, gyr_y_i, gyr_x_i,
                                    acc_z_i, acc_y_i, acc_x_i}; // see RULE2
        pay[8*`NOPB_R28_MAG +: 96] = {mag_z_i, mag_y_i, mag_x_i};
        pay[8*`NOPB_R28_TEMP +: 32] = imu_temp_i; // see RULE3
        pay[8*`NOPB_R28_RSV0 +: 32] = 32'h0; // see RULE3
        pay[8*`NOPB_R28_RSV1 +: 32] = 32'h0;
      end
      `NOPB_ID_RAWGNSS:
      begin
        // Raw receiver values, no offset or arm applied; see RULE4
        // The corrected solution never enters this path; see RULE5
        // Corrected data only feeds packets outside this block; see RULE6
        pay[8*`NOPB_R29_SECS +: 32] =
          32'(rx_gate({32'h0, gnss_secs_i}, gnss_rx_i[0])); // see RULE8
        pay[8*`NOPB_R29_USEC +: 32] =
          32'(rx_gate({32'h0, gnss_usec_i}, gnss_rx_i[1]));
        pay[8*`NOPB_R29_LAT +: 64] = rx_gate(gnss_lat_i, gnss_rx_i[2]);
        pay[8*`NOPB_R29_LON +: 64] = rx_gate(gnss_lon_i, gnss_rx_i[3]);
        pay[8*`NOPB_R29_HGT +: 64] = rx_gate(gnss_hgt_i, gnss_rx_i[4]);
        pay[8*`NOPB_R29_VN +: 32] =
          32'(rx_gate({32'h0, gnss_vn_i}, gnss_rx_i[5]));
        pay[8*`NOPB_R29_VE +: 32] =
          32'(rx_gate({32'h0, gnss_ve_i}, gnss_rx_i[6]));
        pay[8*`NOPB_R29_VD +: 32] =
          32'(rx_gate({32'h0, gnss_vd_i}, gnss_rx_i[7]));
        pay[8*`NOPB_R29_LATSD +: 32] =
          32'(rx_gate({32'h0, gnss_lat_sd_i}, gnss_rx_i[8])); // see RULE9
        pay[8*`NOPB_R29_LONSD +: 32] =
          32'(rx_gate({32'h0, gnss_lon_sd_i}, gnss_rx_i[9]));
        pay[8*`NOPB_R29_HGTSD +: 32] =
          32'(rx_gate({32'h0, gnss_hgt_sd_i}, gnss_rx_i[10]));
        pay[8*`NOPB_R29_TILT +: 32] =
          32'(rx_gate({32'h0, gnss_tilt_i}, gnss_rx_i[11])); // see RULE10
        pay[8*`NOPB_R29_HDG +: 32] =
          32'(rx_gate({32'h0, gnss_hdg_i}, gnss_rx_i[12]));
        pay[8*`NOPB_R29_TILTSD +: 32] =
          32'(rx_gate({32'h0, gnss_tilt_sd_i}, gnss_rx_i[13]));
        pay[8*`NOPB_R29_HDGSD +: 32] =
          32'(rx_gate({32'h0, gnss_hdg_sd_i}, gnss_rx_i[14]));
        pay[8*`NOPB_R29_STATUS +: 16] = status; // see RULE11
      end
      `NOPB_ID_SATS:
      begin
        pay[8*`NOPB_R30_HPD +: 32] = 32'(rx_gate(
          {32'h0, horizontal_precision_dilution_i}, sats_rx_i[0]));
        pay[8*`NOPB_R30_VPD +: 32] = 32'(rx_gate(
          {32'h0, vertical_precision_dilution_i}, sats_rx_i[1]));
        pay[8*`NOPB_R30_CNT +: 40] = 40'(rx_gate({24'h0, cnt_sbas_i,
          cnt_galileo_i, cnt_beidou_i, cnt_glonass_i, cnt_gps_i},
          1'b1)) & {{8{sats_rx_i[6]}}, {8{sats_rx_i[5]}},
          {8{sats_rx_i[4]}}, {8{sats_rx_i[3]}},
          {8{sats_rx_i[2]}}}; // see RULE14
      end
      default:
        pay = '0;
    endcase
  end

  // ****************************************
  // Satellite list
  // ****************************************

  // Codes beyond the defined set are stored as unknown
  assign sys_code = (sat_system_i > `NOPB_SYS_MAX) ?
                    nopb_pkg::SYS_UNKNOWN : sat_system_i; // see RULE17

  // Packed entry, system code in the lowest byte
  assign entry = {
    8'(rx_gate({56'h0, sat_snr_i}, sat_rx_i[5])),
    16'(rx_gate({48'h0, sat_azim_i}, sat_rx_i[4])),
    8'(rx_gate({56'h0, sat_elev_i}, sat_rx_i[3])),
    8'(rx_gate({56'h0, sat_freq_i}, sat_rx_i[2])), // see RULE19
    8'(rx_gate({56'h0, satellite_number_i}, sat_rx_i[1])),
    8'(rx_gate({60'h0, sys_code}, sat_rx_i[0]))}; // see RULE16

  nopb_sat_table u_table (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .wr_i(sat_wr_i),
    .wr_idx_i(sat_wr_idx_i),
    .wr_entry_i(entry),
    .rd_idx_i(ent_r),
    .rd_byte_i(sub_r),
    .rd_data_o(tbl_byte)
  );

  // ****************************************
  // Sequencing
  // ****************************************

  assign supported = (req_type_i >= `NOPB_ID_QSTD) &&
                     (req_type_i <= `NOPB_ID_SATLIST);
  assign take = req_i && req_ready_o && supported;
  assign load = (st_r == nopb_pkg::ST_SEND) && (left_r != 16'h0) &&
                (!out_valid_o || out_ready_i);
  assign fin = out_valid_o && out_ready_i && out_last_o;

  // Idle until a request, busy until the last byte is taken
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      st_r <= nopb_pkg::ST_IDLE;
      req_ready_o <= 1'b1;
    end
    else if (take && pkt_len(req_type_i, sat_count_i) != 16'h0)
    begin
      st_r <= nopb_pkg::ST_SEND;
      req_ready_o <= 1'b0; // see RULE21
    end
    else if (fin)
    begin
      st_r <= nopb_pkg::ST_IDLE;
      req_ready_o <= 1'b1; // see RULE21
    end
  end

  // Snapshot of the payload and its header facts
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      pay_r <= '0;
      type_r <= 8'h0;
      out_type_o <= 8'h0;
      out_len_o <= 16'h0;
    end
    else if (take)
    begin
      pay_r <= pay;
      type_r <= req_type_i;
      out_type_o <= req_type_i;
      out_len_o <= pkt_len(req_type_i, sat_count_i);
    end
  end

  // Byte position counters
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      left_r <= 16'h0;
      idx_r <= 7'h0;
      ent_r <= 5'h0;
      sub_r <= 3'h0;
    end
    else if (take)
    begin
      left_r <= pkt_len(req_type_i, sat_count_i);
      idx_r <= 7'h0;
      ent_r <= 5'h0;
      sub_r <= 3'h0;
    end
    else if (load)
    begin
      left_r <= left_r - 16'h1;
      idx_r <= idx_r + 7'h1;
      if (sub_r == 3'(`NOPB_SAT_ENTRY_LEN - 8'h1))
      begin
        sub_r <= 3'h0; // see RULE15
        ent_r <= ent_r + 5'h1;
      end
      else
        sub_r <= sub_r + 3'h1;
    end
  end

  // Output byte stage held until the framer takes it
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o <= 8'h0;
      out_last_o <= 1'b0;
    end
    else if (load)
    begin
      out_valid_o <= 1'b1;
      out_data_o <= (type_r == `NOPB_ID_SATLIST) ? tbl_byte :
                    pay_r[idx_r*8 +: 8]; // see RULE20
      out_last_o <= (left_r == 16'h1);
    end
    else if (out_ready_i)
    begin
      out_valid_o <= 1'b0;
      out_last_o <= 1'b0;
    end
  end

  // Completion and refusal pulses
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      done_o <= 1'b0;
      req_error_o <= 1'b0;
    end
    else
    begin
      done_o <= fin ||
                (take && pkt_len(req_type_i, sat_count_i) == 16'h0);
      req_error_o <= req_i && req_ready_o && !supported;
    end
  end

endmodule : nopb_packet_builder

/* verilog/nopb_sat_table.sv */
`timescale 1ns/1ns
`include "nopb_params.svh"

module nopb_sat_table (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic [4:0] wr_idx_i,
  input wire logic [55:0] wr_entry_i,
  input wire logic [4:0] rd_idx_i,
  input wire logic [2:0] rd_byte_i,
  output logic [7:0] rd_data_o
);

  logic [55:0] mem_r [`NOPB_SAT_DEPTH];

  // Entry storage, cleared at reset
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < `NOPB_SAT_DEPTH; i++)
        mem_r[i] <= 56'h0;
    end
    else if (wr_i)
      mem_r[wr_idx_i] <= wr_entry_i;
  end

  // Byte select within one entry, low byte first
  assign rd_data_o = mem_r[rd_idx_i][rd_byte_i*8 +: 8];

endmodule : nopb_sat_table
